/* common/clock_gen_pkg.sv */
package clock_gen_pkg;

    // ----
    // register indices, byte address is four times the index
    // ----
    localparam logic [15:0] IDX_COMMAND_STATUS = 16'hFFA0;
    localparam logic [15:0] IDX_MULT_LOW = 16'hFFA2;
    localparam logic [15:0] IDX_MULT_HIGH = 16'hFFA4;
    localparam logic [15:0] IDX_DIVIDER_SETUP = 16'hFFA6;
    localparam logic [15:0] IDX_LOOP_LOW = 16'hFFA8;
    localparam logic [15:0] IDX_LOOP_HIGH = 16'hFFAA;
    localparam logic [15:0] IDX_PRESCALE_DIV = 16'hFFAC;

    // ----
    // command and status bit positions
    // ----
    localparam int BIT_NORMAL_RELOAD = 0;
    localparam int BIT_QUICK_RELOAD = 1;
    localparam int BIT_CORE_ENABLE = 2;
    localparam int BIT_CLOCK_STABLE = 3;
    localparam int BIT_LOOP_VALID = 4;
    localparam int BIT_FIXED_NORMAL = 5;
    localparam int BIT_FIXED_QUICK = 6;

    // ----
    // reset values
    // ----
    localparam logic [7:0] RST_COMMAND_STATUS = 8'h0C;
    localparam logic [7:0] RST_MULT_LOW = 8'hCF;
    localparam logic [7:0] RST_MULT_HIGH = 8'h03;
    localparam logic [4:0] RST_DIVIDER = 5'h08;
    localparam logic [7:0] RST_LOOP_LOW = 8'h00;
    localparam logic [5:0] RST_LOOP_HIGH = 6'h00;
    localparam logic [4:0] RST_PRESCALE_DIV = 5'h17;
    localparam logic [4:0] PRESCALE_BY_ONE = 5'h00;

    // hardwired constants for the fixed 96 MHz rate (plain defaults)
    localparam logic [15:0] FIXED_MULT_VALUE = 16'h0000;
    localparam logic [4:0] FIXED_DIVIDER_VALUE = 5'h00;

    // ----
    // bus constants
    // ----
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic HRESP_OKAY = 1'b0;

    // read access sequencing
    typedef enum logic [1:0] {
        BUS_IDLE = 2'b00,
        BUS_READ_WAIT = 2'b01
    } bus_state_t;

endpackage

/* logic/core_prescaler.sv */
`timescale 1ns/10ps
// ----
// five bit pre-scaler, divides the source clock by divisor plus one
// ----
module core_prescaler (
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic clk_en,
    // load request
    input wire logic load,
    input wire logic [4:0] load_divisor,
    // outputs
    output logic [4:0] divisor,
    output logic core_tick
);
    import clock_gen_pkg::*;

    logic [4:0] count; // counts down from divisor
    logic [4:0] next_count;
    logic next_tick;

    // reload on wrap, a new divisor restarts the cycle at once
    assign next_tick = (count == 5'h00);
    assign next_count = next_tick ? divisor : 5'(count - 5'h01);

    // divider state, divide by one out of reset
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            divisor <= PRESCALE_BY_ONE;
            count <= PRESCALE_BY_ONE;
            core_tick <= 1'b0;
        end else if (clk_en) begin
            if (load) begin
                divisor <= load_divisor;
                count <= load_divisor;
                core_tick <= 1'b1;
            end else begin
                count <= next_count;
                core_tick <= next_tick;
            end
        end
    end
endmodule

/* logic/freq_multiplier_control_regs.sv */
`timescale 1ns/10ps
// Contract
// - normal reload loads buffered multiplier and divider
// - quick reload adds buffered loop values
// - fixed normal lock loads hardwired constants
// - fixed quick lock adds programmed loop values
// - reload commands force pre-scaler divide by one; written with a fixed lock, the divisor is loaded instead
// - fixed lock commands load pre-scaler from divisor
// - command bits are write-only, read zero
// - bit 2 shows core clock enable status
// - bit 3 shows stable oscillator output
// - bit 4 flags valid loop low read
// - multiplier writes only fill setup buffer
// - multiplier reads return value in effect
// - reset values 0C, CF, 03
// - pre-scaler divides by divisor plus one
// - five bit divider setup, upper bits reserved
module freq_multiplier_control_regs (
    // clock, enable and reset
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic clk_en,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // status from the clock generator (asynchronous levels)
    input wire logic core_power_domain_enabled,
    input wire logic output_clock_stable,
    // loop value feedback (same clock)
    input wire logic loop_value_read_valid,
    input wire logic [13:0] measured_loop_value,
    // frequency multiplier load
    output logic normal_reload_pulse,
    output logic quick_reload_pulse,
    output logic fixed_rate_normal_lock_pulse,
    output logic fixed_rate_quick_lock_pulse,
    output logic [15:0] active_mult_value,
    output logic [4:0] active_divider_value,
    output logic [13:0] active_loop_value,
    // core clock pre-scaler
    output logic [4:0] prescale_divisor_active,
    output logic core_clock_tick
);
    import clock_gen_pkg::*;

    // ----
    // helpers
    // ----

    // register hit: index times four is the byte address
    function automatic logic reg_hit(input logic [31:0] addr, input logic [15:0] idx);
        reg_hit = (addr[17:2] == idx);
    endfunction

    // ----
    // storage
    // ----
    logic [7:0] mult_low_setup; // buffered until a reload
    logic [7:0] mult_high_setup;
    logic [4:0] divider_setup; // five bit field
    logic [7:0] loop_low_setup;
    logic [5:0] loop_high_setup;
    logic [4:0] core_prescale_divisor; // last value written

    // bus pipeline
    bus_state_t bus_state;
    logic wr_pending; // write data phase outstanding
    logic [31:0] addr_q; // address of the pending access

    // synchronised status
    logic core_enable_sync;
    logic clock_stable_sync;

    // pre-scaler load request
    logic prescale_load;
    logic [4:0] prescale_load_value;
    logic [4:0] prescale_current;
    logic prescale_tick;

    // ----
    // bus decode
    // ----
    wire addr_phase = hsel && hready && (htrans == HTRANS_NONSEQ);
    wire take_write = addr_phase && hwrite;
    wire take_read = addr_phase && !hwrite;
    // write lands at the edge closing its data phase
    wire do_write = wr_pending && hreadyout;

    wire wr_command = do_write && reg_hit(addr_q, IDX_COMMAND_STATUS);
    wire wr_mult_low = do_write && reg_hit(addr_q, IDX_MULT_LOW);
    wire wr_mult_high = do_write && reg_hit(addr_q, IDX_MULT_HIGH);
    wire wr_divider = do_write && reg_hit(addr_q, IDX_DIVIDER_SETUP);
    wire wr_loop_low = do_write && reg_hit(addr_q, IDX_LOOP_LOW);
    wire wr_loop_high = do_write && reg_hit(addr_q, IDX_LOOP_HIGH);
    wire wr_prescale = do_write && reg_hit(addr_q, IDX_PRESCALE_DIV);

    // command strobes, one per accepted write of a one
    wire cmd_normal = wr_command && hwdata[BIT_NORMAL_RELOAD];
    wire cmd_quick = wr_command && hwdata[BIT_QUICK_RELOAD];
    wire cmd_fixed_normal = wr_command && hwdata[BIT_FIXED_NORMAL];
    wire cmd_fixed_quick = wr_command && hwdata[BIT_FIXED_QUICK];
    // a combined write is left undefined for software; here each fires
    // its own strobe and the earlier branches below take priority
    wire any_reload = cmd_normal || cmd_quick;
    wire any_fixed = cmd_fixed_normal || cmd_fixed_quick;

    // ----
    // read data selection
    // ----
    // command bits always read zero, only status shows
    wire [7:0] command_status_rd = {
        1'b0,
        1'b0,
        1'b0,
        loop_value_read_valid,
        clock_stable_sync,
        core_enable_sync,
        2'b00
    };

    // multiplier reads show the value in effect, not the buffer
    wire [7:0] mult_low_rd = active_mult_value[7:0];
    wire [7:0] mult_high_rd = active_mult_value[15:8];

    wire [7:0] read_byte =
        reg_hit(addr_q, IDX_COMMAND_STATUS) ? command_status_rd :
        reg_hit(addr_q, IDX_MULT_LOW) ? mult_low_rd :
        reg_hit(addr_q, IDX_MULT_HIGH) ? mult_high_rd :
        reg_hit(addr_q, IDX_DIVIDER_SETUP) ? {3'b000, active_divider_value} :
        reg_hit(addr_q, IDX_LOOP_LOW) ? measured_loop_value[7:0] :
        reg_hit(addr_q, IDX_LOOP_HIGH) ? {2'b00, active_loop_value[13:8]} :
        reg_hit(addr_q, IDX_PRESCALE_DIV) ? {3'b000, core_prescale_divisor} :
        8'h00; // unmapped reads return zero

    // ----
    // status synchronisers
    // ----

    // core enable defaults to enabled
    level_sync #(
        .RESET_LEVEL(1'b1)
    ) u_core_enable_sync (
        .hclk(hclk),
        .hresetn(hresetn),
        .clk_en(clk_en),
        .async_in(core_power_domain_enabled),
        .sync_out(core_enable_sync)
    );

    // stable output defaults to stable
    level_sync #(
        .RESET_LEVEL(1'b1)
    ) u_clock_stable_sync (
        .hclk(hclk),
        .hresetn(hresetn),
        .clk_en(clk_en),
        .async_in(output_clock_stable),
        .sync_out(clock_stable_sync)
    );

    // ----
    // bus handshake
    // ----

    // writes take no wait state; reads take one so the data is
    // registered and never catches a write landing the same cycle
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            bus_state <= BUS_IDLE;
            wr_pending <= 1'b0;
            addr_q <= 32'h0000_0000;
            hreadyout <= 1'b1;
            hresp <= HRESP_OKAY;
            hrdata <= 32'h0000_0000;
        end else if (clk_en) begin
            case (bus_state)
                BUS_IDLE: begin
                    if (hready) begin
                        wr_pending <= take_write;
                    end
                    if (take_read) begin
                        addr_q <= haddr;
                        hreadyout <= 1'b0;
                        bus_state <= BUS_READ_WAIT;
                    end else if (take_write) begin
                        addr_q <= haddr;
                    end
                end
                BUS_READ_WAIT: begin
                    hrdata <= {24'h00_0000, read_byte};
                    hreadyout <= 1'b1;
                    bus_state <= BUS_IDLE;
                end
                default: begin
                    bus_state <= BUS_IDLE;
                end
            endcase
        end
    end

    // ----
    // setup buffers and divisor register
    // ----

    // writes fill buffers only; the multiplier keeps running
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            mult_low_setup <= RST_MULT_LOW;
            mult_high_setup <= RST_MULT_HIGH;
            divider_setup <= RST_DIVIDER;
            loop_low_setup <= RST_LOOP_LOW;
            loop_high_setup <= RST_LOOP_HIGH;
            core_prescale_divisor <= RST_PRESCALE_DIV;
        end else if (clk_en) begin
            if (wr_mult_low) begin
                mult_low_setup <= hwdata[7:0];
            end
            if (wr_mult_high) begin
                mult_high_setup <= hwdata[7:0];
            end
            if (wr_divider) begin
                divider_setup <= hwdata[4:0];
            end
            if (wr_loop_low) begin
                loop_low_setup <= hwdata[7:0];
            end
            if (wr_loop_high) begin
                loop_high_setup <= hwdata[5:0];
            end
            if (wr_prescale) begin
                core_prescale_divisor <= hwdata[4:0];
            end
        end
    end

    // ----
    // values in effect at the frequency multiplier
    // ----

    // transfers happen only on a command, never on a buffer write
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            active_mult_value <= {RST_MULT_HIGH, RST_MULT_LOW};
            active_divider_value <= RST_DIVIDER;
            active_loop_value <= {RST_LOOP_HIGH, RST_LOOP_LOW};
        end else if (clk_en) begin
            if (cmd_normal) begin
                active_mult_value <= {mult_high_setup, mult_low_setup};
                active_divider_value <= divider_setup;
            end else if (cmd_quick) begin
                active_mult_value <= {mult_high_setup, mult_low_setup};
                active_divider_value <= divider_setup;
                active_loop_value <= {loop_high_setup, loop_low_setup};
            end else if (cmd_fixed_normal) begin
                active_mult_value <= FIXED_MULT_VALUE;
                active_divider_value <= FIXED_DIVIDER_VALUE;
            end else if (cmd_fixed_quick) begin
                active_mult_value <= FIXED_MULT_VALUE;
                active_divider_value <= FIXED_DIVIDER_VALUE;
                active_loop_value <= {loop_high_setup, loop_low_setup};
            end
        end
    end

    // ----
    // command pulses
    // ----

    // one cycle wide, nothing of the command is kept afterwards
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            normal_reload_pulse <= 1'b0;
            quick_reload_pulse <= 1'b0;
            fixed_rate_normal_lock_pulse <= 1'b0;
            fixed_rate_quick_lock_pulse <= 1'b0;
        end else if (clk_en) begin
            normal_reload_pulse <= cmd_normal;
            quick_reload_pulse <= cmd_quick;
            fixed_rate_normal_lock_pulse <= cmd_fixed_normal;
            fixed_rate_quick_lock_pulse <= cmd_fixed_quick;
        end
    end

    // ----
    // pre-scaler
    // ----

    // reloads force divide by one unless a fixed lock is in the same write; fixed locks take the divisor
    assign prescale_load = any_reload || any_fixed;
    assign prescale_load_value = any_fixed ? core_prescale_divisor
                                           : PRESCALE_BY_ONE;

    core_prescaler u_core_prescaler (
        .hclk(hclk),
        .hresetn(hresetn),
        .clk_en(clk_en),
        .load(prescale_load),
        .load_divisor(prescale_load_value),
        .divisor(prescale_current),
        .core_tick(prescale_tick)
    );

    // divisor and tick are already flops inside the pre-scaler
    assign prescale_divisor_active = prescale_current;
    assign core_clock_tick = prescale_tick;

    // hsize is whole-word only on this bus; no lane logic needed
    wire unused_hsize = ^hsize;

endmodule

/* logic/level_sync.sv */
`timescale 1ns/10ps
// ----
// two flop synchroniser for a level from outside the clock domain
// ----
module level_sync (
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic clk_en,
    // level in and out
    input wire logic async_in,
    output logic sync_out
);
    import clock_gen_pkg::*;

    logic meta; // first stage, read only by the second
    parameter logic RESET_LEVEL = 1'b0;

    // two stage capture, frozen while clk_en is low
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            meta <= RESET_LEVEL;
            sync_out <= RESET_LEVEL;
        end else if (clk_en) begin
            meta <= async_in;
            sync_out <= meta;
        end
    end
endmodule

/* sim/fmc_checker_sva.sv */
`timescale 1ns/10ps
// ----
// port checker for the clock generator command registers
// ----
module fmc_checker
    import clock_gen_pkg::*;
(
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic clk_en,
    // bus side
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic hreadyout,
    input wire logic [31:0] hrdata,
    // multiplier and pre-scaler side
    input wire logic normal_reload_pulse,
    input wire logic quick_reload_pulse,
    input wire logic fixed_rate_normal_lock_pulse,
    input wire logic fixed_rate_quick_lock_pulse,
    input wire logic [15:0] active_mult_value,
    input wire logic [4:0] active_divider_value,
    input wire logic [13:0] active_loop_value,
    input wire logic [4:0] prescale_divisor_active,
    input wire logic core_clock_tick
);
    // accepted address phase and command register select
    wire taken = hsel && hready && (htrans == HTRANS_NONSEQ) && clk_en;
    wire cmd_sel = (haddr[17:2] == IDX_COMMAND_STATUS);
    wire [3:0] pulses = {fixed_rate_quick_lock_pulse, fixed_rate_normal_lock_pulse,
                         quick_reload_pulse, normal_reload_pulse};
    wire reload = normal_reload_pulse || quick_reload_pulse;
    wire fixed = fixed_rate_normal_lock_pulse || fixed_rate_quick_lock_pulse;
    logic cmd_dp; // command write in its data phase
    wire [3:0] cmd_bits = cmd_dp ? {hwdata[6], hwdata[5], hwdata[1], hwdata[0]} : 4'h0;
    // remember a command write until its data arrives
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn)
            cmd_dp <= 1'b0;
        else if (clk_en)
            cmd_dp <= taken && hwrite && cmd_sel;
    end
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    sequence s_read;
        taken && !hwrite;
    endsequence
    sequence s_one_wait;
        !hreadyout ##1 hreadyout;
    endsequence
    a_read_wait: assert property (s_read |=> s_one_wait)
        else $error("read did not take exactly one wait state");
    a_cmd_read_zero: assert property ((taken && !hwrite && cmd_sel) |-> ##2
        ((hrdata & 32'h63) == 32'h0)) else $error("command bits read back nonzero");
    a_pulse_cause: assert property (pulses == $past(cmd_bits))
        else $error("command pulse does not match the written bit");
    a_reload_div_one: assert property (reload |->
        prescale_divisor_active == PRESCALE_BY_ONE)
        else $error("reload left the pre-scaler dividing");
    a_fixed_values: assert property (fixed |-> (active_mult_value == FIXED_MULT_VALUE) &&
        (active_divider_value == FIXED_DIVIDER_VALUE)) else $error("fixed rate constants missing");
    a_mult_buffered: assert property ($changed(active_mult_value) |-> (pulses != 4'h0))
        else $error("multiplier changed without a command");
    a_div_buffered: assert property ($changed(active_divider_value) |-> (pulses != 4'h0))
        else $error("divider changed without a command");
    a_loop_quick: assert property ($changed(active_loop_value) |->
        (quick_reload_pulse || fixed_rate_quick_lock_pulse)) else $error("loop value moved");
    a_div_one_tick: assert property ((prescale_divisor_active == 5'h00)[*3] |->
        core_clock_tick) else $error("divide by one missed a tick");
endmodule

bind freq_multiplier_control_regs fmc_checker i_chk (.hclk(hclk), .hresetn(hresetn),
    .clk_en(clk_en), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hrdata(hrdata),
    .normal_reload_pulse(normal_reload_pulse), .quick_reload_pulse(quick_reload_pulse),
    .fixed_rate_normal_lock_pulse(fixed_rate_normal_lock_pulse),
    .fixed_rate_quick_lock_pulse(fixed_rate_quick_lock_pulse),
    .active_mult_value(active_mult_value), .active_divider_value(active_divider_value),
    .active_loop_value(active_loop_value), .prescale_divisor_active(prescale_divisor_active),
    .core_clock_tick(core_clock_tick));

/* sim/freq_loop_model.sv */
`timescale 1ns/10ps
// ----
// far side: multiplier loop status and loop count feedback
// ----
module freq_loop_model #(
    parameter int SETTLE = 12,
    parameter logic [13:0] LOOP_RESULT = 14'h1A5C
) (
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // merged load pulses and levels the bench commands
    input wire logic load_any,
    input wire logic en_level,
    input wire logic stable_level,
    // status and loop feedback
    output logic core_power_domain_enabled,
    output logic output_clock_stable,
    output logic loop_value_read_valid,
    output logic [13:0] measured_loop_value
);
    logic [7:0] settle; // cycles until the loop locks again
    logic [13:0] churn; // changing garbage while the count is unsettled
    assign core_power_domain_enabled = en_level;
    // clock is unstable while relocking
    assign output_clock_stable = stable_level && (settle == 8'h00);
    assign measured_loop_value = loop_value_read_valid ? LOOP_RESULT : churn;
    // relock countdown after every load
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            settle <= 8'h00;
            churn <= 14'h2A55;
            loop_value_read_valid <= 1'b0;
        end else begin
            churn <= ~{churn[12:0], churn[13]};
            if (load_any) begin
                settle <= SETTLE[7:0];
                loop_value_read_valid <= 1'b0;
            end else if (settle != 8'h00) begin
                settle <= settle - 8'h01;
                loop_value_read_valid <= (settle == 8'h01);
            end
        end
    end
endmodule

/* sim/test_freq_multiplier_control_regs.sv */
`timescale 1ns/10ps
module test_freq_multiplier_control_regs;
    import clock_gen_pkg::*;
    // ----
    // stimulus and observed signals
    // ----
    localparam logic [13:0] LOOP_RESULT = 14'h1A5C;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic clk_en = 1'b1;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h2; // word transfers only
    logic [31:0] hwdata = 32'h0;
    logic en_level = 1'b1;
    logic stable_level = 1'b1;
    wire hreadyout, hresp, core_en, stable, valid, tick;
    wire [31:0] hrdata;
    wire [13:0] measured, act_loop;
    wire [15:0] act_mult;
    wire [4:0] act_div, prescale;
    wire [3:0] pulses;
    logic [31:0] rd; // last read data
    int n_mismatch = 0;
    int num_checks = 0;
    freq_multiplier_control_regs i_dut (.hclk(hclk), .hresetn(hresetn), .clk_en(clk_en),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
        .hrdata(hrdata), .core_power_domain_enabled(core_en), .output_clock_stable(stable),
        .loop_value_read_valid(valid), .measured_loop_value(measured),
        .normal_reload_pulse(pulses[0]), .quick_reload_pulse(pulses[1]),
        .fixed_rate_normal_lock_pulse(pulses[2]), .fixed_rate_quick_lock_pulse(pulses[3]),
        .active_mult_value(act_mult), .active_divider_value(act_div),
        .active_loop_value(act_loop), .prescale_divisor_active(prescale),
        .core_clock_tick(tick));
    freq_loop_model #(.SETTLE(12), .LOOP_RESULT(LOOP_RESULT)) i_model (.hclk(hclk),
        .hresetn(hresetn), .load_any(|pulses), .en_level(en_level),
        .stable_level(stable_level), .core_power_domain_enabled(core_en),
        .output_clock_stable(stable), .loop_value_read_valid(valid),
        .measured_loop_value(measured));
    // ----
    // shared tasks
    // ----
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("Error at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    // one single transfer; hready is sampled at each rising edge
    task automatic bus(input logic wr, input logic [15:0] idx, input logic [7:0] wd);
        hsel <= 1'b1;
        htrans <= HTRANS_NONSEQ;
        hwrite <= wr;
        haddr <= {14'h0, idx, 2'h0};
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= {24'h0, wd};
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
        check({31'h0, hresp}, {31'h0, HRESP_OKAY});
    endtask
    // command write, pulse seen once then gone
    task automatic command(input logic [7:0] cmd, input logic [3:0] exp);
        bus(1'b1, IDX_COMMAND_STATUS, cmd);
        @(posedge hclk);
        check({28'h0, pulses}, {28'h0, exp});
        @(posedge hclk);
        check({28'h0, pulses}, 32'h0);
    endtask
    // cycles between two core ticks
    task automatic tick_gap(input int exp);
        int n = 0;
        repeat (8) @(posedge hclk);
        do @(posedge hclk); while (tick !== 1'b1);
        do begin
            @(posedge hclk);
            n++;
        end while (tick !== 1'b1 && n < 64);
        check(n, exp);
    endtask
    task automatic complete_run();
        if (n_mismatch == 0 && num_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    // ----
    // scenarios
    // ----
    task automatic t_reset();
        bus(1'b0, IDX_COMMAND_STATUS, 8'h00);
        check(rd, {24'h0, RST_COMMAND_STATUS});
        bus(1'b0, IDX_MULT_LOW, 8'h00);
        check(rd, {24'h0, RST_MULT_LOW});
        bus(1'b0, IDX_MULT_HIGH, 8'h00);
        check(rd, {24'h0, RST_MULT_HIGH});
        bus(1'b0, 16'hFFB0, 8'h00); // unmapped place reads zero
        check(rd, 32'h0);
    endtask
    task automatic t_fixed();
        bus(1'b1, IDX_LOOP_LOW, 8'h6E);
        bus(1'b1, IDX_LOOP_HIGH, 8'h15);
        bus(1'b1, IDX_PRESCALE_DIV, 8'h05);
        command(8'h20, 4'h4);
        check({act_mult, 11'h0, act_div}, {FIXED_MULT_VALUE, 11'h0, FIXED_DIVIDER_VALUE});
        check({18'h0, act_loop}, {18'h0, 14'h0000});
        check({27'h0, prescale}, 32'h5);
        tick_gap(6);
        // enable low freezes the divider: no tick where one was due
        clk_en <= 1'b0;
        repeat (6) @(posedge hclk);
        check({31'h0, tick}, 32'h0);
        clk_en <= 1'b1;
        command(8'h40, 4'h8);
        check({18'h0, act_loop}, {18'h0, 14'h156E});
        check({27'h0, prescale}, 32'h5);
    endtask
    task automatic t_quick();
        bus(1'b1, IDX_MULT_LOW, 8'h77);
        bus(1'b1, IDX_MULT_HIGH, 8'h01);
        bus(1'b1, IDX_DIVIDER_SETUP, 8'h03);
        bus(1'b1, IDX_LOOP_LOW, 8'h99);
        bus(1'b1, IDX_LOOP_HIGH, 8'h3F);
        command(8'h02, 4'h2);
        check({act_mult, 11'h0, act_div}, {16'h0177, 11'h0, 5'h03});
        check({18'h0, act_loop}, {18'h0, 14'h3F99});
        check({27'h0, prescale}, 32'h0);
        tick_gap(1);
    endtask
    task automatic t_normal();
        command(8'h20, 4'h4);
        bus(1'b1, IDX_MULT_LOW, 8'h5A);
        bus(1'b1, IDX_MULT_HIGH, 8'h12);
        bus(1'b1, IDX_DIVIDER_SETUP, 8'hFD);
        bus(1'b0, IDX_MULT_LOW, 8'h00);
        check(rd, {24'h0, FIXED_MULT_VALUE[7:0]});
        check({16'h0, act_mult}, {16'h0, FIXED_MULT_VALUE});
        command(8'h01, 4'h1);
        check({act_mult, 11'h0, act_div}, {16'h125A, 11'h0, 5'h1D});
        check({27'h0, prescale}, 32'h0);
        bus(1'b0, IDX_MULT_HIGH, 8'h00);
        check(rd, 32'h12);
        bus(1'b0, IDX_COMMAND_STATUS, 8'h00);
        check(rd & 32'h63, 32'h0);
    endtask
    task automatic t_status();
        en_level <= 1'b0;
        stable_level <= 1'b0;
        repeat (4) @(posedge hclk);
        bus(1'b1, IDX_COMMAND_STATUS, 8'h1C); // status bits only, ignored
        bus(1'b0, IDX_COMMAND_STATUS, 8'h00);
        check(rd & 32'h0C, 32'h0);
        en_level <= 1'b1;
        stable_level <= 1'b1;
        repeat (4) @(posedge hclk);
        bus(1'b0, IDX_COMMAND_STATUS, 8'h00);
        check(rd & 32'h0C, 32'h0C);
    endtask
    task automatic t_loop();
        int n = 0;
        command(8'h40, 4'h8);
        bus(1'b0, IDX_COMMAND_STATUS, 8'h00);
        check(rd & 32'h10, 32'h0);
        while (rd[4] !== 1'b1 && n < 20) begin
            bus(1'b0, IDX_COMMAND_STATUS, 8'h00);
            n++;
        end
        bus(1'b0, IDX_LOOP_LOW, 8'h00);
        check(rd, {24'h0, LOOP_RESULT[7:0]});
        bus(1'b0, IDX_LOOP_HIGH, 8'h00);
        check(rd, 32'h3F);
    endtask
    // ----
    // clock, watchdog and main sequence
    // ----
    initial begin
        forever #2.5 hclk = ~hclk;
    end
    // all scenarios need well under a thousand cycles
    initial begin
        #20000;
        n_mismatch++;
        complete_run();
    end
    initial begin
        repeat (5) @(posedge hclk);
        hresetn <= 1'b1;
        t_reset();
        t_fixed();
        t_quick();
        t_normal();
        t_status();
        t_loop();
        complete_run();
    end
endmodule
